// *** hdl/regstat_defs.svh ***
// Purpose: offsets, field positions, reset values of the regulator status and mask bank
// Assumes: AHB-Lite word registers; byte address = 4 * printed index
// Notes:   mask reset values come from the cfg_mask_a/b straps
`ifndef REGSTAT_DEFS_SVH
`define REGSTAT_DEFS_SVH

`define IDX_STEPDOWN_STATUS   8'h1E
`define IDX_LINEAR_STATUS     8'h1F
`define IDX_TOP_MASK_A        8'h20
`define IDX_TOP_MASK_B        8'h21
`define IDX_EVENT_FLAGS       8'h30
`define IDX_TOP_STATE         8'h31

`define BIT_REG1_EN           7
`define BIT_REG1_INVALID      6
`define BIT_REG1_ILIM         4
`define BIT_REG0_EN           3
`define BIT_REG0_INVALID      2
`define BIT_REG0_ILIM         0

`define BIT_PGOOD             7
`define BIT_SYNC_CLK          4
`define BIT_TWARN             2
`define BIT_MEAS              0

`define MASK_A_USED           8'h95
`define MASK_B_USED           8'h01
`define STATUS_RESET          8'h00

`endif

// *** hdl/regstat_pkg.sv ***
// Purpose: types of the regulator status and mask bank
// Assumes: nothing
// Notes:   data phase state only
package regstat_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [0:0] {
        PH_IDLE  = 1'b0,
        PH_WRITE = 1'b1
    } phase_t;
endpackage

// *** hdl/regstat_bank.sv ***
// Purpose: regulator raw status, top event masks and event flags on AHB-Lite
// Assumes: status inputs come from analog circuits, asynchronous to hclk
// Notes:   zero wait state slave, always OKAY
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "regstat_defs.svh"

module regstat_bank (
    // bus clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // ahb-lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    // raw regulator state
    input  wire logic                   stepdown0_enabled,
    input  wire logic                   stepdown1_enabled,
    input  wire logic                   stepdown0_vout_invalid,
    input  wire logic                   stepdown1_vout_invalid,
    input  wire logic                   stepdown0_current_limited,
    input  wire logic                   stepdown1_current_limited,
    input  wire logic                   linear0_enabled,
    input  wire logic                   linear1_enabled,
    input  wire logic                   linear0_vout_invalid,
    input  wire logic                   linear1_vout_invalid,
    input  wire logic                   linear0_current_limited,
    input  wire logic                   linear1_current_limited,
    // top events
    input  wire logic                   power_good_pin_state,
    input  wire logic                   sync_clk_invalid,
    input  wire logic                   thermal_warning_state,
    input  wire logic                   load_meas_ready_pulse,
    // mask reset configuration
    input  wire regstat_pkg::byte_t     cfg_mask_a,
    input  wire regstat_pkg::byte_t     cfg_mask_b,
    // interrupt
    output logic                        irq
);
    import regstat_pkg::*;

    // two-stage synchronisers for all 16 analog levels
    localparam int NSYNC = 16;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;

    assign raw_in = {load_meas_ready_pulse, thermal_warning_state, sync_clk_invalid,
                     power_good_pin_state,
                     linear1_enabled, linear1_vout_invalid, linear1_current_limited,
                     linear0_enabled, linear0_vout_invalid, linear0_current_limited,
                     stepdown1_enabled, stepdown1_vout_invalid, stepdown1_current_limited,
                     stepdown0_enabled, stepdown0_vout_invalid, stepdown0_current_limited};

    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                end else begin
                    sync1_reg[i] <= raw_in[i];
                    sync2_reg[i] <= sync1_reg[i];
                end
            end
        end
    endgenerate

    // status words, reserved bits 5 and 1 tied low
    byte_t stepdown_word;
    byte_t linear_word;
    byte_t top_state_word;
    byte_t status_next;
    byte_t stepdown_status_reg;
    byte_t linear_status_reg;
    byte_t top_state_reg;

    assign stepdown_word = {sync2_reg[5], sync2_reg[4], 1'b0, sync2_reg[3],
                            sync2_reg[2], sync2_reg[1], 1'b0, sync2_reg[0]};
    assign linear_word   = {sync2_reg[11], sync2_reg[10], 1'b0, sync2_reg[9],
                            sync2_reg[8], sync2_reg[7], 1'b0, sync2_reg[6]};
    assign top_state_word = {sync2_reg[12], 2'b00, sync2_reg[13], 1'b0, sync2_reg[14], 2'b00};
    assign status_next   = stepdown_word;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stepdown_status_reg <= `STATUS_RESET;
            linear_status_reg   <= `STATUS_RESET;
            top_state_reg       <= `STATUS_RESET;
        end else begin
            stepdown_status_reg <= status_next;
            linear_status_reg   <= linear_word;
            top_state_reg       <= top_state_word;
        end
    end

    // event edges: rising power good, sync loss, warning, measurement ready
    byte_t prev_reg;
    byte_t event_word;
    assign event_word = {sync2_reg[12] & ~prev_reg[7], 2'b00,
                         sync2_reg[13] & ~prev_reg[4], 1'b0,
                         sync2_reg[14] & ~prev_reg[2], 1'b0,
                         sync2_reg[15] & ~prev_reg[0]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_reg <= 8'h00;
        end else begin
            prev_reg <= {sync2_reg[12], 2'b00, sync2_reg[13], 1'b0, sync2_reg[14], 1'b0,
                         sync2_reg[15]};
        end
    end

    // ahb-lite address phase capture
    logic       addr_valid;
    logic       wr_pend;
    logic [7:0] wr_idx_reg;
    logic [7:0] addr_idx;
    phase_t     phase_reg;

    assign addr_valid = hsel & htrans[1] & hready;
    assign addr_idx   = haddr[9:2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_reg   <= PH_IDLE;
            wr_idx_reg  <= 8'h00;
        end else begin
            wr_idx_reg  <= addr_idx;
            phase_reg   <= (addr_valid & hwrite) ? PH_WRITE : PH_IDLE;
        end
    end

    logic wr_mask_a;
    logic wr_mask_b;
    logic wr_flags;
    // the data phase state alone says whether hwdata is to be written
    assign wr_pend   = (phase_reg == PH_WRITE);
    assign wr_mask_a = wr_pend && (wr_idx_reg == `IDX_TOP_MASK_A);
    assign wr_mask_b = wr_pend && (wr_idx_reg == `IDX_TOP_MASK_B);
    assign wr_flags  = wr_pend && (wr_idx_reg == `IDX_EVENT_FLAGS);

    // masks: reset value caught from straps on the first edge after release
    byte_t mask_a_reg;
    byte_t mask_b_reg;
    logic  strap_done_reg;
    byte_t mask_a_next;
    byte_t mask_b_next;

    assign mask_a_next = !strap_done_reg ? (cfg_mask_a & `MASK_A_USED) :
                         wr_mask_a ? (hwdata[7:0] & `MASK_A_USED) : mask_a_reg;
    assign mask_b_next = !strap_done_reg ? (cfg_mask_b & `MASK_B_USED) :
                         wr_mask_b ? (hwdata[7:0] & `MASK_B_USED) : mask_b_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_done_reg <= 1'b0;
            mask_a_reg     <= 8'h00;
            mask_b_reg     <= 8'h00;
        end else begin
            strap_done_reg <= 1'b1;
            mask_a_reg     <= mask_a_next;
            mask_b_reg     <= mask_b_next;
        end
    end

    // sticky flags: set wins over write-one clear
    byte_t flags_reg;
    byte_t flags_next;
    byte_t clr_word;
    assign clr_word   = wr_flags ? hwdata[7:0] : 8'h00;
    assign flags_next = (flags_reg & ~clr_word) | event_word;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_reg <= 8'h00;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // mask A alone gates the interrupt, mask B gates nothing; flags and state words ignore both
    logic irq_next;
    assign irq_next = |(flags_next & ~mask_a_next & `MASK_A_USED);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_next;
        end
    end

    // read data, registered one cycle after the address phase
    byte_t rd_sel;
    assign rd_sel = (addr_idx == `IDX_STEPDOWN_STATUS) ? stepdown_status_reg :
                    (addr_idx == `IDX_LINEAR_STATUS)   ? linear_status_reg :
                    (addr_idx == `IDX_TOP_MASK_A)      ? mask_a_reg :
                    (addr_idx == `IDX_TOP_MASK_B)      ? mask_b_reg :
                    (addr_idx == `IDX_EVENT_FLAGS)     ? flags_reg :
                    (addr_idx == `IDX_TOP_STATE)       ? top_state_reg : 8'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= (addr_valid & ~hwrite) ? {24'h000000, rd_sel} : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // checks
    property p_stepdown_follows;
        @(posedge hclk) disable iff (!hresetn)
        stepdown_status_reg[`BIT_REG1_EN] == $past(sync2_reg[5]);
    endproperty
    a_stepdown_follows: assert property (p_stepdown_follows)
        else $error("step-down status lags raw state");

    property p_sd0_en;
        @(posedge hclk) disable iff (!hresetn)
        $rose(sync2_reg[2]) |=> stepdown_status_reg[`BIT_REG0_EN];
    endproperty
    a_sd0_en: assert property (p_sd0_en)
        else $error("first converter enable not shown");

    property p_sd_reserved;
        @(posedge hclk) disable iff (!hresetn)
        !stepdown_status_reg[5] && !stepdown_status_reg[1] && !linear_status_reg[5]
        && !linear_status_reg[1];
    endproperty
    a_sd_reserved: assert property (p_sd_reserved)
        else $error("reserved status bit set");

    property p_sd_raw;
        @(posedge hclk) disable iff (!hresetn)
        ##1 stepdown_status_reg[`BIT_REG1_INVALID] == $past(sync2_reg[4])
        && stepdown_status_reg[`BIT_REG1_ILIM] == $past(sync2_reg[3]);
    endproperty
    a_sd_raw: assert property (p_sd_raw)
        else $error("step-down raw bits wrong");

    property p_lin_raw;
        @(posedge hclk) disable iff (!hresetn)
        linear_status_reg[`BIT_REG1_EN] == $past(sync2_reg[11])
        && linear_status_reg[`BIT_REG0_ILIM] == $past(sync2_reg[6]);
    endproperty
    a_lin_raw: assert property (p_lin_raw)
        else $error("linear status bits wrong");

    property p_flag_sticky;
        @(posedge hclk) disable iff (!hresetn)
        flags_reg[`BIT_TWARN] && !(wr_flags && hwdata[`BIT_TWARN]) |=> flags_reg[`BIT_TWARN];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("event flag dropped without clear");

    property p_masked_quiet;
        @(posedge hclk) disable iff (!hresetn)
        strap_done_reg && (mask_a_reg & flags_reg) == flags_reg && flags_reg != 8'h00
        && !wr_mask_a && event_word == 8'h00 |=> !irq;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("masked flag raised interrupt");

    property p_unmasked_irq;
        @(posedge hclk) disable iff (!hresetn)
        (event_word[`BIT_MEAS] || flags_reg[`BIT_MEAS] && !(wr_flags && hwdata[`BIT_MEAS]))
        && !mask_a_next[`BIT_MEAS] |=> irq;
    endproperty
    a_unmasked_irq: assert property (p_unmasked_irq)
        else $error("unmasked event gave no interrupt");

    property p_strap_load;
        @(posedge hclk) disable iff (!hresetn)
        !strap_done_reg |=> mask_b_reg == ($past(cfg_mask_b) & `MASK_B_USED);
    endproperty
    a_strap_load: assert property (p_strap_load)
        else $error("mask not loaded from configuration");

    property p_sd_first_raw;
        @(posedge hclk) disable iff (!hresetn)
        stepdown_status_reg[`BIT_REG0_INVALID] == $past(sync2_reg[1])
        && stepdown_status_reg[`BIT_REG0_ILIM] == $past(sync2_reg[0]);
    endproperty
    a_sd_first_raw: assert property (p_sd_first_raw)
        else $error("first converter raw bits wrong");

    property p_lin_valid;
        @(posedge hclk) disable iff (!hresetn)
        linear_status_reg[`BIT_REG1_INVALID] == $past(sync2_reg[10])
        && linear_status_reg[`BIT_REG0_INVALID] == $past(sync2_reg[7])
        && linear_status_reg[`BIT_REG0_EN] == $past(sync2_reg[8]);
    endproperty
    a_lin_valid: assert property (p_lin_valid)
        else $error("linear validity bits wrong");

    property p_lin_ilim;
        @(posedge hclk) disable iff (!hresetn)
        linear_status_reg[`BIT_REG1_ILIM] == $past(sync2_reg[9]);
    endproperty
    a_lin_ilim: assert property (p_lin_ilim)
        else $error("second linear current limit bit wrong");

    // state word must track the raw levels whatever the masks hold
    property p_top_unmasked;
        @(posedge hclk) disable iff (!hresetn)
        top_state_reg[`BIT_PGOOD] == $past(sync2_reg[12])
        && top_state_reg[`BIT_SYNC_CLK] == $past(sync2_reg[13])
        && top_state_reg[`BIT_TWARN] == $past(sync2_reg[14]);
    endproperty
    a_top_unmasked: assert property (p_top_unmasked)
        else $error("top state bit differs from raw level");

    property p_twarn_irq;
        @(posedge hclk) disable iff (!hresetn)
        flags_reg[`BIT_TWARN] && !mask_a_reg[`BIT_TWARN] |-> irq;
    endproperty
    a_twarn_irq: assert property (p_twarn_irq)
        else $error("unmasked thermal warning flag without interrupt");

    property p_flag_set;
        @(posedge hclk) disable iff (!hresetn)
        event_word[`BIT_PGOOD] |=> flags_reg[`BIT_PGOOD];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("event did not set its flag");

    property p_mask_write;
        @(posedge hclk) disable iff (!hresetn)
        strap_done_reg && wr_mask_a |=> mask_a_reg == ($past(hwdata[7:0]) & `MASK_A_USED);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write kept a reserved bit");

    c_irq:   cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
    c_clear: cover property (@(posedge hclk) disable iff (!hresetn) wr_flags ##1 !irq);
    c_read:  cover property (@(posedge hclk) disable iff (!hresetn) addr_valid && !hwrite);
    c_event: cover property (@(posedge hclk) disable iff (!hresetn) event_word[`BIT_PGOOD]);
endmodule
`default_nettype wire

// *** bench/regstat_bank_tb.sv ***
// Purpose: self-checking bench of the regulator status and event mask bank
// Assumes: zero wait state AHB-Lite slave, 40 MHz hclk, expectations built from the register map
// Notes:   drivers queue expected values, a monitor compares them as results appear
`timescale 1ns/1ps
`default_nettype none
`include "regstat_defs.svh"

module regstat_bank_tb;
    import regstat_pkg::*;

    typedef struct {
        logic        k;
        logic [31:0] v;
    } note_t;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic        probe;
    logic        rd_pend = 1'b0;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [1:0]  htrans;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic [5:0]  sd;
    logic [5:0]  ln;
    logic [3:0]  ev;
    byte_t       cfg_a;
    byte_t       cfg_b;
    note_t       q[$];
    note_t       nt;
    int          n_fail;
    int          cmp_count;
    int          seed;
    int          posn[4] = '{0, 2, 4, 7};

    regstat_bank i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .stepdown0_enabled(sd[0]), .stepdown0_vout_invalid(sd[1]),
        .stepdown0_current_limited(sd[2]), .stepdown1_enabled(sd[3]),
        .stepdown1_vout_invalid(sd[4]), .stepdown1_current_limited(sd[5]),
        .linear0_enabled(ln[0]), .linear0_vout_invalid(ln[1]),
        .linear0_current_limited(ln[2]), .linear1_enabled(ln[3]),
        .linear1_vout_invalid(ln[4]), .linear1_current_limited(ln[5]),
        .power_good_pin_state(ev[3]), .sync_clk_invalid(ev[2]),
        .thermal_warning_state(ev[1]), .load_meas_ready_pulse(ev[0]),
        .cfg_mask_a(cfg_a), .cfg_mask_b(cfg_b), .irq(irq)
    );

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    function automatic logic [31:0] fmt(input logic [5:0] s);
        return {24'h0, s[3], s[4], 1'b0, s[5], s[0], s[1], 1'b0, s[2]};
    endfunction

    // caller sits just after an edge; ends on the data phase edge so calls run back to back
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        q.push_back('{1'b0, e});
        bus(1'b0, idx, 32'h0);
    endtask

    task automatic chk_irq(input logic e);
        repeat (2) @(posedge hclk);
        q.push_back('{1'b1, {31'h0, e}});
        probe <= 1'b1;
        @(posedge hclk);
        probe <= 1'b0;
    endtask

    // hrdata is read before this edge's update lands, i.e. the data phase value
    always @(posedge hclk) begin
        if ((rd_pend || probe) && q.size() > 0) begin
            nt = q.pop_front();
            cmp_count++;
            if ((nt.k ? {31'h0, irq} : hrdata) !== nt.v) begin
                n_fail++;
                $display("ERROR %s expected %h seen %h", nt.k ? "irq" : "hrdata", nt.v,
                         nt.k ? {31'h0, irq} : hrdata);
            end
        end
        if (rd_pend && hresp !== 1'b0) begin
            n_fail++;
            $display("ERROR hresp expected 0 seen %b", hresp);
        end
        rd_pend <= hsel && hreadyout && htrans[1] && !hwrite;
    end

    task automatic results;
        if (q.size() != 0) begin
            n_fail++;
            $display("ERROR queue expected 0 seen %0d", q.size());
        end
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #(25ns * 20000);
        n_fail++;
        results;
    end

    initial begin
        seed = 5511;
        {hresetn, hsel, hwrite, probe} = '0;
        {haddr, hwdata, htrans, sd, ln, ev} = '0;
        cfg_a = byte_t'($random(seed));
        cfg_b = byte_t'($random(seed));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`IDX_STEPDOWN_STATUS, 32'h0);
        rd(`IDX_LINEAR_STATUS, 32'h0);
        rd(`IDX_TOP_MASK_A, {24'h0, cfg_a & `MASK_A_USED});
        rd(`IDX_TOP_MASK_B, {24'h0, cfg_b & `MASK_B_USED});
        bus(1'b1, 8'h25, 32'hFF);
        rd(8'h25, 32'h0);
        // ten random levels per bank sample some of the enable, validity and limit combinations
        repeat (10) begin
            sd <= 6'($random(seed));
            ln <= 6'($random(seed));
            repeat (4) @(posedge hclk);
            bus(1'b1, `IDX_STEPDOWN_STATUS, 32'hFF);
            bus(1'b1, `IDX_LINEAR_STATUS, 32'hFF);
            rd(`IDX_STEPDOWN_STATUS, fmt(sd));
            rd(`IDX_LINEAR_STATUS, fmt(ln));
        end
        bus(1'b1, `IDX_TOP_MASK_B, 32'hFF);
        rd(`IDX_TOP_MASK_B, {24'h0, `MASK_B_USED});
        bus(1'b1, `IDX_TOP_MASK_A, 32'hFF);
        rd(`IDX_TOP_MASK_A, {24'h0, `MASK_A_USED});
        for (int i = 3; i >= 0; i--) begin
            ev[i] <= 1'b1;
            repeat (5) @(posedge hclk);
            rd(`IDX_EVENT_FLAGS, 32'h1 << posn[i]);
            rd(`IDX_TOP_STATE, (i > 0) ? (32'h1 << posn[i]) : 32'h0);
            chk_irq(1'b0);
            bus(1'b1, `IDX_TOP_MASK_A, {24'h0, `MASK_A_USED} & ~(32'h1 << posn[i]));
            chk_irq(1'b1);
            rd(`IDX_TOP_STATE, (i > 0) ? (32'h1 << posn[i]) : 32'h0);
            ev[i] <= 1'b0;
            bus(1'b1, `IDX_EVENT_FLAGS, 32'h0);
            rd(`IDX_EVENT_FLAGS, 32'h1 << posn[i]);
            bus(1'b1, `IDX_EVENT_FLAGS, 32'h1 << posn[i]);
            rd(`IDX_EVENT_FLAGS, 32'h0);
            chk_irq(1'b0);
            bus(1'b1, `IDX_TOP_MASK_A, {24'h0, `MASK_A_USED});
        end
        repeat (2) @(posedge hclk);
        results;
    end
endmodule
`default_nettype wire
